// File: core/twi_pkg.sv
/*
  Shared constants and types for the two-wire bus controller: register
  offsets, control bit positions, status codes, reset values and timing.
  Assumes a 200 MHz pclk and a 32-bit APB register bus.
*/
package twi_pkg;
  localparam logic [7:0] OFS_CONTROL_SET = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_OWN_ADDR = 8'h0C;
  localparam logic [7:0] OFS_CONTROL_CLR = 8'h18;
  localparam logic [7:0] OFS_HALF_PERIOD = 8'h1C;

  localparam int BIT_ENABLE = 6;
  localparam int BIT_BEGIN = 5;
  localparam int BIT_HALT = 4;
  localparam int BIT_IFLAG = 3;
  localparam int BIT_ACK_EN = 2;

  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'hF8;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_OWN_ADDR = 8'h00;

  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RESTART = 8'h10;
  localparam logic [7:0] ST_MT_ADDR_ACK = 8'h18;
  localparam logic [7:0] ST_MT_ADDR_NACK = 8'h20;
  localparam logic [7:0] ST_MT_DATA_ACK = 8'h28;
  localparam logic [7:0] ST_MT_DATA_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_MR_ADDR_ACK = 8'h40;
  localparam logic [7:0] ST_MR_ADDR_NACK = 8'h48;
  localparam logic [7:0] ST_MR_DATA_ACK = 8'h50;
  localparam logic [7:0] ST_MR_DATA_NACK = 8'h58;
  localparam logic [7:0] ST_SR_ADDR = 8'h60;
  localparam logic [7:0] ST_SR_ARB_ADDR = 8'h68;
  localparam logic [7:0] ST_SR_GC = 8'h70;
  localparam logic [7:0] ST_SR_ARB_GC = 8'h78;
  localparam logic [7:0] ST_SR_DATA_ACK = 8'h80;
  localparam logic [7:0] ST_SR_DATA_NACK = 8'h88;
  localparam logic [7:0] ST_SR_GC_ACK = 8'h90;
  localparam logic [7:0] ST_SR_GC_NACK = 8'h98;
  localparam logic [7:0] ST_SR_STOP = 8'hA0;
  localparam logic [7:0] ST_ST_ADDR = 8'hA8;
  localparam logic [7:0] ST_ST_ARB_ADDR = 8'hB0;
  localparam logic [7:0] ST_ST_DATA_ACK = 8'hB8;
  localparam logic [7:0] ST_ST_DATA_NACK = 8'hC0;
  localparam logic [7:0] ST_IDLE = 8'hF8;

  localparam logic [7:0] GENERAL_CALL = 8'h00;
  localparam int FILTER_CYCLES = 3;
  localparam logic [15:0] RST_HALF_PERIOD = 16'h00FA;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } bus_events_t;
endpackage

// File: core/twi_line_filter.sv
/*
  Synchroniser and spike filter for the two bus lines, plus START, STOP
  and clock edge detection. Assumes raw pin levels from outside pclk.
*/
`timescale 1ns/10ps
module twi_line_filter
  import twi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire bus_lines_t raw,
  output bus_lines_t clean,
  output bus_events_t events
);
  bus_lines_t meta_q, sync_q, clean_q, prev_q;
  logic [1:0] cnt_q [2];
  logic [1:0] sync_v, clean_v;

  assign sync_v = {sync_q.scl, sync_q.sda};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      // RL15 spike reject: level must stand three clocks
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q[g] <= 2'h0;
          clean_v[g] <= 1'b1;
        end else if (clk_en) begin
          if (sync_v[g] == clean_v[g]) begin
            cnt_q[g] <= 2'h0;
          end else if (cnt_q[g] == 2'(FILTER_CYCLES - 1)) begin
            cnt_q[g] <= 2'h0;
            clean_v[g] <= sync_v[g];
          end else begin
            cnt_q[g] <= cnt_q[g] + 2'h1;
          end
        end
      end
    end
  endgenerate

  assign clean_q = '{scl: clean_v[1], sda: clean_v[0]};
  assign clean = clean_q;

  // RL15 two-flop sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '{scl: 1'b1, sda: 1'b1};
      sync_q <= '{scl: 1'b1, sda: 1'b1};
      prev_q <= '{scl: 1'b1, sda: 1'b1};
    end else if (clk_en) begin
      meta_q <= raw;
      sync_q <= meta_q;
      prev_q <= clean_q;
    end
  end

  // RL25 start and stop detect
  assign events.start = clean_q.scl && prev_q.scl && prev_q.sda && !clean_q.sda;
  assign events.stop = clean_q.scl && prev_q.scl && !prev_q.sda && clean_q.sda;
  assign events.scl_rise = clean_q.scl && !prev_q.scl;
  assign events.scl_fall = !clean_q.scl && prev_q.scl;
endmodule

// File: core/twi_apb_regs.sv
/*
  APB slave decode for the controller registers. Produces one-cycle
  write strobes and a combinational read word. Assumes zero wait states.
*/
`timescale 1ns/10ps
module twi_apb_regs
  import twi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0] control,
  input wire logic [7:0] status,
  input wire logic [7:0] data,
  input wire logic [7:0] own_addr,
  input wire logic [15:0] half_period,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic wr_set,
  output logic wr_clr,
  output logic wr_data,
  output logic wr_addr,
  output logic wr_half,
  output logic rd_data
);
  logic access, mapped;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic pslverr_q;

  assign access = psel && penable && clk_en;
  assign mapped = (paddr == OFS_CONTROL_SET) || (paddr == OFS_STATUS) ||
                  (paddr == OFS_DATA) || (paddr == OFS_OWN_ADDR) ||
                  (paddr == OFS_CONTROL_CLR) || (paddr == OFS_HALF_PERIOD);
  assign wr_set = access && pwrite && (paddr == OFS_CONTROL_SET);
  assign wr_clr = access && pwrite && (paddr == OFS_CONTROL_CLR);
  assign wr_data = access && pwrite && (paddr == OFS_DATA);
  assign wr_addr = access && pwrite && (paddr == OFS_OWN_ADDR);
  assign wr_half = access && pwrite && (paddr == OFS_HALF_PERIOD);
  assign rd_data = access && !pwrite && (paddr == OFS_DATA);
  assign rdata_d = (paddr == OFS_CONTROL_SET) ? {24'h000000, control} :
                   (paddr == OFS_STATUS) ? {24'h000000, status} :
                   (paddr == OFS_DATA) ? {24'h000000, data} :
                   (paddr == OFS_OWN_ADDR) ? {24'h000000, own_addr} :
                   (paddr == OFS_HALF_PERIOD) ? {16'h0000, half_period} :
                   32'h00000000;
  // Combinational read keeps zero wait states
  assign prdata = (psel && !pwrite) ? rdata_d : prdata_q;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (access && !pwrite) begin
      prdata_q <= rdata_d;
      pslverr_q <= !mapped;
    end
  end
endmodule

// File: core/twi_engine.sv
/*
  Byte-oriented two-wire bus controller: master and slave, transmit and
  receive, with arbitration, address compare and status codes.
  Assumes open-drain pads outside; APB master on pclk.
*/
// Operation
// RL1: Moves one byte at a time; master/slave transmit and receive modes.
// RL2: With slave enabled, watches own and general call address; match sets flag.
// RL3: Master request waits for a free bus before starting.
// RL4: Lost arbitration drops to slave at once; own address still recognised.
// RL5: Control bits: enable 6, begin 5, halt 4, flag 3, ack enable 2.
// RL6: Ack enable low means no address is acknowledged, no slave mode.
// RL7: Writing one to clear register flag bit clears the flag; zeros ignored.
// RL8: First master byte is 7-bit address plus direction, 0 for write.
// RL9: Master transmitter sends 8 bits then samples one acknowledge bit.
// RL10: Begin request issues START once bus free, sets flag, status 0x08.
// RL11: After address and ack: 0x18, 0x20, 0x38 or slave 0x68, 0x78, 0xB0.
// RL12: Master read address phase: 0x40, 0x48, 0x38 or slave codes.
// RL13: Enable and ack enable set: acknowledge own and general call address.
// RL14: Addressed slave: direction 0 receives, 1 transmits; flag set after address.
// RL15: Lines synchronised; pulses under three clocks rejected.
// RL16: Own address in upper seven bits; bit 0 enables general call 0x00.
// RL17: Compare received address to own and first byte to 0x00.
// RL18: Shift left, bit 7 first; first received bit lands in bit 7.
// RL19: Bus value shifted in while shifting out; register holds last byte.
// RL20: Master transmitter losing a one becomes slave, finishes byte clocks only; code stops its clocks at once.
// RL21: Master receiver: low SDA during its not-acknowledge means lost arbitration.
// RL22: Transfer ends in STOP or repeated START; bus stays claimed.
// RL23: Status latched when flag sets; stable till cleared; low bits zero.
// RL24: SCL held low after each byte and ack while flag set.
// RL25: START and STOP detected in every mode; bus-free state tracked.
`timescale 1ns/10ps
module twi_engine
  import twi_pkg::*;
#(
  parameter logic [15:0] HALF_PERIOD_DEFAULT = RST_HALF_PERIOD
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port0_serial_data_pin_i,
  output logic port0_serial_data_pin_o,
  output logic port0_serial_data_pin_oe,
  input wire logic port0_serial_clock_pin_i,
  output logic port0_serial_clock_pin_o,
  output logic port0_serial_clock_pin_oe,
  output logic interrupt_req
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_BIT = 3'b010,
    S_ACK = 3'b011,
    S_HOLD = 3'b100,
    S_STOP = 3'b101,
    S_SLAVE = 3'b110
  } phase_t;

  bus_lines_t clean;
  bus_events_t ev;
  logic wr_set, wr_clr, wr_data, wr_addr, wr_half, rd_data;
  logic [7:0] control_q, status_q, data_q, own_addr_q;
  logic [15:0] half_q, tick_q;
  phase_t phase_q;
  logic [3:0] bit_q;
  logic master_q, tx_q, addr_phase_q, busy_q, sda_drive_q, scl_drive_q;
  logic lost_q, no_clocks_q, ack_out_q, sda_out_q, scl_hi_q, gc_q, addressed_q;
  logic [7:0] status_d;
  logic set_flag;
  logic block_enable, begin_request, halt_request, iflag, ack_enable;
  logic tick_done, own_match, gc_match, slave_ack;
  logic [7:0] data_shift;
  logic [7:0] control_wr;

  assign block_enable = control_q[BIT_ENABLE];
  assign begin_request = control_q[BIT_BEGIN];
  assign halt_request = control_q[BIT_HALT];
  assign iflag = control_q[BIT_IFLAG];
  assign ack_enable = control_q[BIT_ACK_EN];
  assign tick_done = (tick_q == 16'h0000);
  assign data_shift = {data_q[6:0], clean.sda};
  // RL16 own address and general call enable
  assign own_match = (data_q[7:1] == own_addr_q[7:1]);
  // RL17 general call compare
  assign gc_match = (data_q == GENERAL_CALL) && own_addr_q[0];
  // RL6 RL13 acknowledge only with both bits set
  assign slave_ack = block_enable && ack_enable && (own_match || gc_match);
  // RL5 writable bits only
  assign control_wr = pwdata[7:0] & 8'h7C;

  twi_line_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .raw('{scl: port0_serial_clock_pin_i, sda: port0_serial_data_pin_i}),
    .clean(clean),
    .events(ev)
  );

  twi_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .control(control_q),
    .status(status_q),
    .data(data_q),
    .own_addr(own_addr_q),
    .half_period(half_q),
    .prdata(prdata),
    .pslverr(pslverr),
    .wr_set(wr_set),
    .wr_clr(wr_clr),
    .wr_data(wr_data),
    .wr_addr(wr_addr),
    .wr_half(wr_half),
    .rd_data(rd_data)
  );

  // Zero-wait-state slave
  assign pready = 1'b1;

  // Open-drain: drive only ever pulls low
  assign port0_serial_data_pin_o = 1'b0;
  assign port0_serial_clock_pin_o = 1'b0;
  assign port0_serial_data_pin_oe = sda_drive_q;
  assign port0_serial_clock_pin_oe = scl_drive_q;
  assign interrupt_req = control_q[BIT_IFLAG];

  // Software registers and the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= RST_CONTROL;
      own_addr_q <= RST_OWN_ADDR;
      half_q <= HALF_PERIOD_DEFAULT;
      status_q <= RST_STATUS;
    end else if (clk_en) begin
      if (wr_addr) begin
        own_addr_q <= pwdata[7:0];
      end
      if (wr_half) begin
        half_q <= pwdata[15:0];
      end
      if (wr_set) begin
        control_q <= control_q | control_wr;
      end
      // RL7 write-one clear; a set in the same cycle wins
      if (wr_clr) begin
        control_q <= control_q & ~control_wr;
      end
      if (set_flag) begin
        control_q[BIT_IFLAG] <= 1'b1;
        // RL23 status latched with the flag
        status_q <= {status_d[7:3], 3'b000};
      end else if (wr_clr && control_wr[BIT_IFLAG]) begin
        status_q <= ST_IDLE;
      end
      if (phase_q == S_START && tick_done && clean.scl && !clean.sda) begin
        control_q[BIT_BEGIN] <= 1'b0;
      end
      if (phase_q == S_STOP && tick_done && scl_hi_q) begin
        control_q[BIT_HALT] <= 1'b0;
      end
    end
  end

  // RL25 bus busy between START and STOP
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (clk_en) begin
      if (ev.start) begin
        busy_q <= 1'b1;
      end else if (ev.stop) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Byte engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= S_IDLE;
      tick_q <= 16'h0000;
      bit_q <= 4'h0;
      data_q <= RST_DATA;
      master_q <= 1'b0;
      tx_q <= 1'b0;
      addr_phase_q <= 1'b0;
      sda_drive_q <= 1'b0;
      scl_drive_q <= 1'b0;
      lost_q <= 1'b0;
      no_clocks_q <= 1'b0;
      ack_out_q <= 1'b0;
      sda_out_q <= 1'b1;
      scl_hi_q <= 1'b0;
      gc_q <= 1'b0;
      addressed_q <= 1'b0;
      set_flag <= 1'b0;
      status_d <= ST_IDLE;
    end else if (clk_en) begin
      set_flag <= 1'b0;
      if (!tick_done) begin
        tick_q <= tick_q - 16'h0001;
      end
      if (wr_data && !master_q && !addressed_q) begin
        data_q <= pwdata[7:0];
      end else if (wr_data && iflag) begin
        data_q <= pwdata[7:0];
      end
      if (!block_enable) begin
        phase_q <= S_IDLE;
        master_q <= 1'b0;
        addressed_q <= 1'b0;
        sda_drive_q <= 1'b0;
        scl_drive_q <= 1'b0;
      end else if (ev.stop && !master_q) begin
        // RL25 stop ends any slave transfer
        phase_q <= S_IDLE;
        addressed_q <= 1'b0;
        sda_drive_q <= 1'b0;
        if (addressed_q && !tx_q) begin
          status_d <= ST_SR_STOP;
          set_flag <= 1'b1;
        end
      end else if (ev.start && !master_q && phase_q != S_START) begin
        // RL4 RL2 foreign START: address watch
        phase_q <= S_SLAVE;
        bit_q <= 4'h0;
        addr_phase_q <= 1'b1;
        addressed_q <= 1'b0;
        sda_drive_q <= 1'b0;
      end else begin
        unique case (phase_q)
          S_IDLE: begin
            // RL3 RL10 wait for free bus before START
            if (begin_request && !busy_q && !iflag) begin
              sda_drive_q <= 1'b1;
              tick_q <= half_q;
              phase_q <= S_START;
            end
          end
          S_START: begin
            if (tick_done && clean.scl && !clean.sda) begin
              master_q <= 1'b1;
              lost_q <= 1'b0;
              no_clocks_q <= 1'b0;
              addr_phase_q <= 1'b1;
              scl_drive_q <= 1'b1;
              // RL10 START done
              status_d <= master_q ? ST_RESTART : ST_START;
              set_flag <= 1'b1;
              phase_q <= S_HOLD;
            end else if (tick_done && clean.scl) begin
              sda_drive_q <= 1'b1;
            end
          end
          S_HOLD: begin
            // RL24 clock held low until flag cleared
            scl_drive_q <= master_q || addressed_q;
            if (!iflag && !set_flag) begin
              if (master_q && halt_request) begin
                sda_drive_q <= 1'b1;
                tick_q <= half_q;
                scl_hi_q <= 1'b0;
                phase_q <= S_STOP;
              end else if (master_q && begin_request) begin
                // RL22 repeated START keeps bus claimed
                sda_drive_q <= 1'b0;
                scl_drive_q <= 1'b0;
                tick_q <= half_q;
                phase_q <= S_START;
              end else begin
                // RL8 first byte is address plus direction
                if (master_q && addr_phase_q) begin
                  tx_q <= 1'b1;
                end
                sda_out_q <= data_q[7];
                sda_drive_q <= (master_q || tx_q) ? !data_q[7] : 1'b0;
                bit_q <= 4'h0;
                tick_q <= half_q;
                scl_hi_q <= 1'b0;
                scl_drive_q <= master_q;
                phase_q <= S_BIT;
              end
            end
          end
          S_BIT, S_ACK, S_SLAVE: begin
            // RL1 master clock generator; slaves follow SCL
            if (master_q && tick_done) begin
              if (!scl_hi_q) begin
                scl_drive_q <= 1'b0;
                scl_hi_q <= 1'b1;
                tick_q <= half_q;
              end else if (clean.scl) begin
                scl_drive_q <= 1'b1;
                scl_hi_q <= 1'b0;
                tick_q <= half_q;
              end
            end
            if (ev.scl_rise && phase_q != S_ACK) begin
              // RL18 RL19 shift in the bus value every bit
              data_q <= data_shift;
              // RL20 driven one seen low: arbitration lost
              if (master_q && tx_q && sda_out_q && !clean.sda) begin
                lost_q <= 1'b1;
                master_q <= 1'b0;
                sda_drive_q <= 1'b0;
              end
              bit_q <= bit_q + 4'h1;
            end
            if (ev.scl_fall && phase_q != S_ACK) begin
              if (bit_q == 4'h8) begin
                // RL9 one acknowledge bit after eight
                phase_q <= S_ACK;
                if (addr_phase_q && !master_q) begin
                  gc_q <= gc_match;
                  addressed_q <= slave_ack;
                  // RL14 direction picks receive or transmit
                  tx_q <= slave_ack && data_q[0];
                  sda_drive_q <= slave_ack;
                end else begin
                  if (master_q && addr_phase_q) begin
                    tx_q <= !data_q[0];
                  end
                  sda_drive_q <= !tx_q && ack_enable &&
                                 (master_q || addressed_q);
                end
                ack_out_q <= !tx_q && ack_enable;
              end else begin
                sda_out_q <= data_q[7];
                sda_drive_q <= ((master_q && !lost_q) || (addressed_q && tx_q)) &&
                               tx_q && !data_q[7];
              end
            end
            if (ev.scl_rise && phase_q == S_ACK) begin
              // RL21 own not-acknowledge overruled
              if (master_q && !tx_q && !ack_out_q && !clean.sda) begin
                lost_q <= 1'b1;
                master_q <= 1'b0;
                no_clocks_q <= 1'b1;
              end
              if (master_q && addr_phase_q) begin
                // RL11 RL12 master address results
                status_d <= tx_q ? (clean.sda ? ST_MT_ADDR_NACK : ST_MT_ADDR_ACK) :
                            (clean.sda ? ST_MR_ADDR_NACK : ST_MR_ADDR_ACK);
              end else if (master_q) begin
                status_d <= tx_q ? (clean.sda ? ST_MT_DATA_NACK : ST_MT_DATA_ACK) :
                            (ack_out_q ? ST_MR_DATA_ACK : ST_MR_DATA_NACK);
              end else if (addr_phase_q && addressed_q) begin
                // RL4 RL17 slave address match, with or without lost arbitration
                status_d <= tx_q ? (lost_q ? ST_ST_ARB_ADDR : ST_ST_ADDR) :
                            gc_q ? (lost_q ? ST_SR_ARB_GC : ST_SR_GC) :
                            (lost_q ? ST_SR_ARB_ADDR : ST_SR_ADDR);
              end else if (addressed_q) begin
                status_d <= tx_q ? (clean.sda ? ST_ST_DATA_NACK : ST_ST_DATA_ACK) :
                            gc_q ? (ack_out_q ? ST_SR_GC_ACK : ST_SR_GC_NACK) :
                            (ack_out_q ? ST_SR_DATA_ACK : ST_SR_DATA_NACK);
              end else if (lost_q) begin
                status_d <= ST_ARB_LOST;
              end
            end
            if (ev.scl_fall && phase_q == S_ACK) begin
              addr_phase_q <= 1'b0;
              lost_q <= lost_q && !(master_q || addressed_q);
              sda_drive_q <= 1'b0;
              if (master_q || addressed_q || lost_q) begin
                // RL2 RL24 flag and stretch after byte and ack
                set_flag <= 1'b1;
                scl_drive_q <= 1'b1;
                phase_q <= master_q || addressed_q ? S_HOLD : S_IDLE;
              end else begin
                phase_q <= S_IDLE;
              end
            end
          end
          S_STOP: begin
            // RL22 STOP: SCL up, then SDA up
            if (tick_done && !scl_hi_q) begin
              scl_drive_q <= 1'b0;
              scl_hi_q <= 1'b1;
              tick_q <= half_q;
            end else if (tick_done && scl_hi_q && clean.scl) begin
              sda_drive_q <= 1'b0;
              master_q <= 1'b0;
              phase_q <= S_IDLE;
            end
          end
          default: begin
            phase_q <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// File: verification/twi_engine_asserts.sv
/* Port checker for twi_engine, bound at the foot.
   Assumes open-drain pads with pull-ups outside. */
`timescale 1ns/10ps
module twi_engine_asserts
  import twi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic interrupt_req,
  input wire logic port0_serial_data_pin_i,
  input wire logic port0_serial_data_pin_oe,
  input wire logic port0_serial_clock_pin_i,
  input wire logic port0_serial_clock_pin_oe
);
  wire si = port0_serial_data_pin_i;
  wire so = port0_serial_data_pin_oe;
  wire ci = port0_serial_clock_pin_i;
  wire irq = interrupt_req;
  wire rd = psel && penable && !pwrite;
  wire clr = psel && penable && pwrite && paddr == OFS_CONTROL_CLR && irq;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_free; $rose(so) && ci |-> $past(si, 2); endproperty
  a_free: assert property (p_free) else $error("start on busy bus");
  property p_go; $rose(so) && ci |-> ##[1:300] irq; endproperty
  a_go: assert property (p_go) else $error("no flag after start");
  property p_hold; irq [*8] ##0 !ci |-> port0_serial_clock_pin_oe; endproperty
  a_hold: assert property (p_hold) else $error("clock not held");
  property p_clr; clr && pwdata[BIT_IFLAG] |=> !irq; endproperty
  a_clr: assert property (p_clr) else $error("flag kept");
  property p_keep; clr && !pwdata[BIT_IFLAG] |=> irq; endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_ctrl; rd && paddr == 8'h00 |-> prdata[BIT_IFLAG] == irq && prdata[1:0] == 2'h0;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control read");
  property p_lo; rd && paddr == OFS_STATUS |-> prdata[2:0] == 3'h0; endproperty
  a_lo: assert property (p_lo) else $error("status low bits");
  property p_idle; rd && paddr == OFS_STATUS && !irq |-> prdata[7:0] == ST_IDLE; endproperty
  a_idle: assert property (p_idle) else $error("idle status");
endmodule
bind twi_engine twi_engine_asserts u_chk (.*);

// File: verification/twi_bus_partner.sv
/* Slave device on the two-wire bus.
   Assumes wires resolved with pull-ups. */
`timescale 1ns/10ps
module twi_bus_partner (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_on,
  output logic sda_oe,
  output logic [7:0] got
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh;
  initial sda_oe = 1'h0;
  always @(negedge sda) if (scl) cnt = 4'h0;
  always @(posedge scl) begin
    if (cnt < 4'h8) sh = {sh[6:0], sda};
    cnt = cnt + 4'h1;
    if (cnt == 4'h8) got = sh;
  end
  always @(negedge scl) begin
    sda_oe = cnt == 4'h8 && ack_on;
    if (cnt > 4'h8) cnt = 4'h0;
  end
endmodule

// File: verification/i2c_master_slave_engine_test.sv
/* Bench top: APB and bus master tasks around twi_engine.
   Needs twi_pkg, the partner and the checker. */
`timescale 1ns/10ps
module i2c_master_slave_engine_test
  import twi_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pull_scl = 1'h0, pull_sda = 1'h0, ack_on = 1'h1, ack;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  logic [7:0] rv [5] = '{RST_CONTROL, RST_STATUS, RST_DATA, RST_OWN_ADDR, 8'h00};
  logic [7:0] dat [4] = '{8'hA4, 8'h3C, 8'hC3, 8'h00};
  logic [7:0] st [3] = '{ST_MT_ADDR_ACK, ST_MT_DATA_ACK, ST_MT_DATA_NACK};
  int err_total = 0, n_compared = 0, cyc = 0;
  wire pready, interrupt_req, d_oe, c_oe, p_oe;
  wire [31:0] prdata;
  wire [7:0] got;
  wire scl = !(c_oe || pull_scl);
  wire sda = !(d_oe || p_oe || pull_sda);
  always #2.5 pclk = !pclk;
  twi_engine #(.HALF_PERIOD_DEFAULT(16'h0020)) u_dut (.pclk, .presetn, .clk_en(1'h1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(),
    .port0_serial_data_pin_i(sda), .port0_serial_data_pin_o(), .port0_serial_data_pin_oe(d_oe),
    .port0_serial_clock_pin_i(scl), .port0_serial_clock_pin_o(),
    .port0_serial_clock_pin_oe(c_oe), .interrupt_req);
  twi_bus_partner u_slave (.scl, .sda, .ack_on, .sda_oe(p_oe), .got);
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wflag;
    do @(posedge pclk); while (interrupt_req !== 1'h1);
  endtask
  // 125 ns a bit: 12 or 13 cycles a phase
  task automatic step(input logic c, input logic d);
    pull_scl <= c;
    pull_sda <= d;
    repeat (12) @(posedge pclk);
  endtask
  task automatic send(input logic [7:0] v);
    for (int i = 8; i >= 0; i--) begin
      pull_scl <= 1'h1;
      @(posedge pclk);
      step(1'h1, i > 0 ? !v[i - 1] : 1'h0);
      step(1'h0, pull_sda);
      ack = sda;
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk) if (++cyc == 20000) begin
    err_total++;
    conclude;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      apb(1'h0, 8'(i * 4), 32'h0);
      chk(q, {24'h0, rv[i]});
    end
    $display("reset test done");
    apb(1'h1, OFS_CONTROL_SET, 32'h60);
    wflag;
    apb(1'h0, OFS_STATUS, 32'h0);
    chk(q, {24'h0, ST_START});
    apb(1'h1, OFS_DATA, 32'hA4);
    apb(1'h1, OFS_CONTROL_CLR, 32'h20);
    @(posedge pclk);
    chk(interrupt_req, 1'h1);
    for (int k = 0; k < 3; k++) begin
      ack_on <= k < 2;
      apb(1'h1, OFS_CONTROL_CLR, 32'h08);
      wflag;
      apb(1'h0, OFS_STATUS, 32'h0);
      chk(q, {24'h0, st[k]});
      chk(got, dat[k]);
      apb(1'h1, OFS_DATA, {24'h0, dat[k + 1]});
    end
    apb(1'h1, OFS_CONTROL_SET, 32'h10);
    apb(1'h1, OFS_CONTROL_CLR, 32'h08);
    while (!(sda && scl)) @(posedge pclk);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk(q, {24'h0, ST_IDLE});
    $display("master test done");
    ack_on <= 1'h0;
    apb(1'h1, OFS_OWN_ADDR, 32'h6C);
    apb(1'h1, OFS_CONTROL_SET, 32'h04);
    for (int k = 0; k < 2; k++) begin
      step(1'h0, 1'h1);
      step(1'h1, 1'h1);
      send(8'h6C);
      step(1'h1, 1'h0);
      chk(ack, 32'(k));
      chk(interrupt_req, k == 0);
      if (k == 0) begin
        apb(1'h0, OFS_STATUS, 32'h0);
        chk(q, {24'h0, ST_SR_ADDR});
        apb(1'h1, OFS_CONTROL_CLR, 32'h0C);
      end
      step(1'h1, 1'h1);
      step(1'h0, 1'h1);
      step(1'h0, 1'h0);
      apb(1'h1, OFS_CONTROL_CLR, 32'h08);
    end
    $display("slave test done");
    conclude;
  end
endmodule
